/* bench/fpr_pipe_model.sv */
// Pipeline-side partner of the reduce slice: register file and extension control register.
`timescale 1ns/1ps
`default_nettype none
module fpr_pipe_model (
    input wire logic sys_clk_i,            // Core clock.
    input wire logic rst_n_i,              // Synchronous reset, active low.
    input wire logic wb_valid_i,           // Destination write pulse.
    input wire logic [4:0] dest_idx_i,     // Destination register index.
    input wire logic [31:0] result_i,      // Destination value.
    input wire logic ctrl_we_i,            // Control register write pulse.
    input wire logic [31:0] ctrl_wdata_i,  // Control register new value.
    input wire logic [31:0] ctrl_init_i,   // Control value loaded during reset.
    output logic [31:0] ctrl_o             // Current control register.
);
    logic [31:0] gpr_reg [32];

    ////////////////////////////////////////////////////////////////////////////
    // Control is seeded in reset so that unrelated bits can show any damage.
    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            ctrl_o <= ctrl_init_i;
        end else begin
            if (ctrl_we_i) begin
                ctrl_o <= ctrl_wdata_i;
            end
            if (wb_valid_i) begin
                gpr_reg[dest_idx_i] <= result_i;
            end
        end
    end
endmodule
`default_nettype wire

/* bench/test_fpr_reduce.sv */
// Self-checking bench for the precision-reduce slice with its pipeline partner.
`timescale 1ns/1ps
`default_nettype none
module test_fpr_reduce;
    logic sys_clk = 1'b0;
    logic rst_n = 1'b0;
    logic issue = 1'b0;
    logic [31:0] instr = 32'h00000000;
    logic [31:0] first_src = 32'h00000000;
    logic [31:0] second_src = 32'h00000000;
    logic ext_present = 1'b1;
    logic ext_enable = 1'b1;
    logic [31:0] ctrl_before = 32'h00000000;
    logic wb_valid, ctrl_we, ri_exc, disabled_exc;
    logic [4:0] dest_idx;
    logic [31:0] result, ctrl_wdata, ctrl;
    int num_errors = 0;
    int n_compared = 0;
    int cycles = 0;

    always #5 sys_clk = ~sys_clk;

    fpr_reduce i_fpr_reduce (.sys_clk_i(sys_clk), .rst_n_i(rst_n), .issue_i(issue), .instr_i(instr),
        .first_src_i(first_src), .second_src_i(second_src), .ext_present_i(ext_present),
        .ext_enable_i(ext_enable), .ctrl_i(ctrl), .wb_valid_o(wb_valid), .dest_idx_o(dest_idx),
        .result_o(result), .ctrl_we_o(ctrl_we), .ctrl_wdata_o(ctrl_wdata), .ri_exc_o(ri_exc),
        .disabled_exc_o(disabled_exc));
    fpr_pipe_model i_fpr_pipe_model (.sys_clk_i(sys_clk), .rst_n_i(rst_n), .wb_valid_i(wb_valid),
        .dest_idx_i(dest_idx), .result_i(result), .ctrl_we_i(ctrl_we), .ctrl_wdata_i(ctrl_wdata),
        .ctrl_init_i(32'h12000005), .ctrl_o(ctrl));

    ////////////////////////////////////////////////////////////////////////////
    // The whole run needs well under a hundred cycles, so a hang is cut off early.
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 2000) begin
            num_errors++;
            print_verdict();
        end
    end

    task automatic print_verdict();
        $display("compared %0d mismatches %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_compared++;
        if (got !== exp) begin
            num_errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask

    // Issues one word for a single cycle; outputs are registered at the next edge.
    task automatic do_op(input logic [9:0] minor, input logic bit10, input logic [31:0] f, input logic [31:0] s);
        @(posedge sys_clk);
        #1;
        issue = 1'b1;
        instr = {fpr_pkg::MAJOR_GROUP, 5'h02, 5'h01, 5'h07, bit10, minor};
        first_src = f;
        second_src = s;
        ctrl_before = ctrl;
        @(posedge sys_clk);
        #1;
        issue = 1'b0;
    endtask

    // Judges the answer cycle, then the control register the partner holds one edge later.
    task automatic expect_out(input logic wb, input logic [31:0] res, input logic fl, input logic ri, input logic dis);
        chk("wb_valid", {31'h0, wb}, {31'h0, wb_valid});
        if (wb) begin
            chk("dest_idx", 32'h7, {27'h0, dest_idx});
            chk("result", res, result);
        end
        chk("ctrl_we", {31'h0, fl}, {31'h0, ctrl_we});
        chk("ri_exc", {31'h0, ri}, {31'h0, ri_exc});
        chk("disabled_exc", {31'h0, dis}, {31'h0, disabled_exc});
        @(posedge sys_clk);
        #1;
        chk("wb_valid pulse end", 32'h0, {31'h0, wb_valid});
        chk("ctrl", fl ? (ctrl_before | fpr_pkg::FLAG_MASK) : ctrl_before, ctrl);
        if (wb) begin
            chk("register file", res, i_fpr_pipe_model.gpr_reg[7]);
        end
    endtask

    task automatic test_trunc();
        do_op(fpr_pkg::MINOR_TRUNC_WH, 1'b0, 32'h12345678, 32'h9abcdef0);
        expect_out(1'b1, 32'h12349abc, 1'b0, 1'b0, 1'b0);
        do_op(fpr_pkg::MINOR_TRUNC_HB, 1'b0, 32'h12345678, 32'h9abcdef0);
        expect_out(1'b1, 32'h12569ade, 1'b0, 1'b0, 1'b0);
    endtask

    task automatic test_clamp();
        do_op(fpr_pkg::MINOR_CLAMP_HB, 1'b0, 32'h7f817f80, 32'h80001234);
        expect_out(1'b1, 32'hffff0024, 1'b1, 1'b0, 1'b0);
        do_op(fpr_pkg::MINOR_CLAMP_HB, 1'b0, 32'h7f800000, 32'h00ff0080);
        expect_out(1'b1, 32'hff000101, 1'b0, 1'b0, 1'b0);
        do_op(fpr_pkg::MINOR_CLAMP_HB, 1'b0, 32'h00013f80, 32'h7f808001);
        expect_out(1'b1, 32'h007fff00, 1'b1, 1'b0, 1'b0);
    endtask

    task automatic test_round();
        do_op(fpr_pkg::MINOR_ROUND_WH, 1'b0, 32'h7fff8000, 32'h12348000);
        expect_out(1'b1, 32'h7fff1235, 1'b1, 1'b0, 1'b0);
        do_op(fpr_pkg::MINOR_ROUND_WH, 1'b0, 32'hffff7fff, 32'h80000000);
        expect_out(1'b1, 32'hffff8000, 1'b0, 1'b0, 1'b0);
        do_op(fpr_pkg::MINOR_ROUND_WH, 1'b0, 32'h12348000, 32'h7fff8000);
        expect_out(1'b1, 32'h12357fff, 1'b1, 1'b0, 1'b0);
        do_op(fpr_pkg::MINOR_ROUND_WH, 1'b0, 32'h12348000, 32'hffff7fff);
        expect_out(1'b1, 32'h1235ffff, 1'b0, 1'b0, 1'b0);
    endtask

    task automatic test_refused();
        ext_present = 1'b0;
        do_op(fpr_pkg::MINOR_CLAMP_HB, 1'b0, 32'h80008000, 32'h80008000);
        expect_out(1'b0, 32'h0, 1'b0, 1'b1, 1'b0);
        ext_present = 1'b1;
        ext_enable = 1'b0;
        do_op(fpr_pkg::MINOR_ROUND_WH, 1'b0, 32'h7fff8000, 32'h7fff8000);
        expect_out(1'b0, 32'h0, 1'b0, 1'b0, 1'b1);
        ext_enable = 1'b1;
        do_op(fpr_pkg::MINOR_CLAMP_HB, 1'b1, 32'h80008000, 32'h80008000);
        expect_out(1'b0, 32'h0, 1'b0, 1'b0, 1'b0);
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // Main sequence: reset for twenty cycles, then each scenario in turn.
    initial begin
        repeat (20) @(posedge sys_clk);
        #1;
        rst_n = 1'b1;
        test_trunc();
        test_clamp();
        test_round();
        test_refused();
        print_verdict();
    end
endmodule
`default_nettype wire

/* src/fpr_pkg.sv */
// Constants and types shared by the precision-reduce datapath slice.
package fpr_pkg;
    // Instruction word field positions.
    localparam int MAJOR_HI = 31;
    localparam int MAJOR_LO = 26;
    localparam int SECOND_HI = 25;
    localparam int SECOND_LO = 21;
    localparam int FIRST_HI = 20;
    localparam int FIRST_LO = 16;
    localparam int DEST_HI = 15;
    localparam int DEST_LO = 11;
    localparam int ZERO_BIT = 10;
    localparam int MINOR_HI = 9;
    localparam int MINOR_LO = 0;

    // Opcode values.
    localparam logic [5:0] MAJOR_GROUP = 6'h00;
    localparam logic [9:0] MINOR_TRUNC_WH = 10'h0ed;
    localparam logic [9:0] MINOR_TRUNC_HB = 10'h0ad;
    localparam logic [9:0] MINOR_CLAMP_HB = 10'h16d;
    localparam logic [9:0] MINOR_ROUND_WH = 10'h12d;

    // Arithmetic constants.
    localparam int FLAG_BIT = 22;
    localparam logic [14:0] CLAMP_LIMIT = 15'h7f80;
    localparam logic [7:0] BYTE_MAX = 8'hff;
    localparam logic [7:0] BYTE_MIN = 8'h00;
    localparam logic [32:0] ROUND_CONST = 33'h000008000;
    localparam logic [31:0] Q31_MAX = 32'h7fffffff;
    localparam logic [31:0] FLAG_MASK = 32'h00400000;

    // Reset values of the write-back stage.
    localparam logic [31:0] WORD_RST = 32'h00000000;
    localparam logic [4:0] IDX_RST = 5'h00;

    // Operation selected by the decoder.
    typedef enum logic [2:0] {
        FPR_OP_NONE,
        FPR_OP_TRUNC_WH,
        FPR_OP_TRUNC_HB,
        FPR_OP_CLAMP_HB,
        FPR_OP_ROUND_WH
    } fpr_op_t;
endpackage

/* src/fpr_reduce.sv */
// Precision-reduce datapath slice: decode, compute, one write-back stage.
`timescale 1ns/1ps
`default_nettype none
module fpr_reduce (
    input wire logic sys_clk_i,            // Core clock, 100 MHz.
    input wire logic rst_n_i,              // Synchronous reset, active low.
    input wire logic issue_i,              // Instruction word valid this cycle.
    input wire logic [31:0] instr_i,       // Instruction word.
    input wire logic [31:0] first_src_i,   // Value of the first source register.
    input wire logic [31:0] second_src_i,  // Value of the second source register.
    input wire logic ext_present_i,        // Extension implemented.
    input wire logic ext_enable_i,         // Extension enabled by software.
    input wire logic [31:0] ctrl_i,        // Current extension control register.
    output logic wb_valid_o,               // Destination write pulse.
    output logic [4:0] dest_idx_o,         // Destination register index.
    output logic [31:0] result_o,          // Destination value.
    output logic ctrl_we_o,                // Control register write pulse.
    output logic [31:0] ctrl_wdata_o,      // Control register new value.
    output logic ri_exc_o,                 // Reserved-instruction exception pulse.
    output logic disabled_exc_o            // Extension-disabled exception pulse.
);

    ////////////////////////////////////////////////////////////////////////////
    // Functions.

    // Matches a word against one minor code of the reduction group.
    function automatic logic is_op_fn(input logic [31:0] w, input logic [9:0] minor);
        is_op_fn = (w[fpr_pkg::MAJOR_HI:fpr_pkg::MAJOR_LO] == fpr_pkg::MAJOR_GROUP) &&
                   !w[fpr_pkg::ZERO_BIT] &&
                   (w[fpr_pkg::MINOR_HI:fpr_pkg::MINOR_LO] == minor);
    endfunction

    // Clamps one signed halfword to an unsigned byte; the top bit reports a clamp.
    function automatic logic [8:0] clamp_to_byte_fn(input logic [15:0] h);
        logic [8:0] r;
        r = {1'b0, h[14:7]};
        if (h[15]) begin
            r = {1'b1, fpr_pkg::BYTE_MIN};
        end else if (h[14:0] > fpr_pkg::CLAMP_LIMIT) begin
            r = {1'b1, fpr_pkg::BYTE_MAX};
        end
        return r;
    endfunction

    // Rounds, saturates and truncates one word; the top bit reports saturation.
    function automatic logic [16:0] round_saturate_truncate_fn(input logic [31:0] w);
        logic [32:0] sum;
        logic ovf;
        sum = {w[31], w} + fpr_pkg::ROUND_CONST;
        ovf = sum[32] != sum[31];
        if (ovf) begin
            sum = {1'b0, fpr_pkg::Q31_MAX};
        end
        return {ovf, sum[31:16]};
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Decode.

    // One-hot matches of the four operations.
    wire logic hit_trunc_wh = is_op_fn(instr_i, fpr_pkg::MINOR_TRUNC_WH);
    wire logic hit_trunc_hb = is_op_fn(instr_i, fpr_pkg::MINOR_TRUNC_HB);
    wire logic hit_clamp_hb = is_op_fn(instr_i, fpr_pkg::MINOR_CLAMP_HB);
    wire logic hit_round_wh = is_op_fn(instr_i, fpr_pkg::MINOR_ROUND_WH);
    wire logic hit_any = hit_trunc_wh | hit_trunc_hb | hit_clamp_hb | hit_round_wh;

    // The only faults are availability faults; data never raises one.
    wire logic take = issue_i & hit_any;
    wire logic ri_next = take & !ext_present_i;
    wire logic dis_next = take & ext_present_i & !ext_enable_i;
    wire logic exec = take & ext_present_i & ext_enable_i;

    ////////////////////////////////////////////////////////////////////////////
    // Datapath.

    // Plain truncations.
    wire logic [31:0] res_trunc_wh = {first_src_i[31:16], second_src_i[31:16]};
    wire logic [31:0] res_trunc_hb = {first_src_i[31:24], first_src_i[15:8],
                                      second_src_i[31:24], second_src_i[15:8]};

    // Four clamped elements, first source high to second source low.
    wire logic [63:0] halves = {first_src_i, second_src_i};
    logic [8:0] clamp_el [4];
    logic [31:0] res_clamp_hb;
    logic [3:0] clamp_hit;
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++) begin : g_clamp
            assign clamp_el[gi] = clamp_to_byte_fn(halves[16*gi +: 16]);
            assign res_clamp_hb[8*gi +: 8] = clamp_el[gi][7:0];
            assign clamp_hit[gi] = clamp_el[gi][8];
        end
    endgenerate

    // Two rounded elements.
    wire logic [16:0] round_hi = round_saturate_truncate_fn(first_src_i);
    wire logic [16:0] round_lo = round_saturate_truncate_fn(second_src_i);
    wire logic [31:0] res_round_wh = {round_hi[15:0], round_lo[15:0]};

    // Result select and flag cause; the plain truncations never raise the flag.
    wire logic [31:0] res_sel = hit_trunc_wh ? res_trunc_wh :
                                hit_trunc_hb ? res_trunc_hb :
                                hit_clamp_hb ? res_clamp_hb : res_round_wh;
    wire logic flag_next = exec & ((hit_clamp_hb & (|clamp_hit)) |
                                   (hit_round_wh & (round_hi[16] | round_lo[16])));

    ////////////////////////////////////////////////////////////////////////////
    // Write-back stage.

    // Result and control update leave in the same cycle so a later read sees the flag.
    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            wb_valid_o <= 1'b0;
            dest_idx_o <= fpr_pkg::IDX_RST;
            result_o <= fpr_pkg::WORD_RST;
            ctrl_we_o <= 1'b0;
            ctrl_wdata_o <= fpr_pkg::WORD_RST;
            ri_exc_o <= 1'b0;
            disabled_exc_o <= 1'b0;
        end else begin
            wb_valid_o <= exec;
            dest_idx_o <= instr_i[fpr_pkg::DEST_HI:fpr_pkg::DEST_LO];
            result_o <= res_sel;
            ctrl_we_o <= flag_next;
            ctrl_wdata_o <= ctrl_i | fpr_pkg::FLAG_MASK;
            ri_exc_o <= ri_next;
            disabled_exc_o <= dis_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Assertions.

    default clocking cb @(posedge sys_clk_i);
    endclocking
    default disable iff (!rst_n_i);

    // An executable issue of a given kind.
    sequence s_exec_trunc_wh;
        issue_i && hit_trunc_wh && ext_present_i && ext_enable_i;
    endsequence
    sequence s_exec_trunc_hb;
        issue_i && hit_trunc_hb && ext_present_i && ext_enable_i;
    endsequence
    sequence s_exec_clamp;
        issue_i && hit_clamp_hb && ext_present_i && ext_enable_i;
    endsequence
    sequence s_exec_round;
        issue_i && hit_round_wh && ext_present_i && ext_enable_i;
    endsequence

    // An issue that must end in an availability fault instead of a write-back.
    sequence s_take_absent;
        issue_i && hit_any && !ext_present_i;
    endsequence
    sequence s_take_disabled;
        issue_i && hit_any && ext_present_i && !ext_enable_i;
    endsequence

    property p_decode_only;
        wb_valid_o |-> ($past(instr_i[fpr_pkg::MAJOR_HI:fpr_pkg::MAJOR_LO]) == fpr_pkg::MAJOR_GROUP) &&
            !$past(instr_i[fpr_pkg::ZERO_BIT]);
    endproperty
    a_decode_only: assert property (p_decode_only) else $error("write-back without group opcode");

    property p_clamp_issue;
        s_exec_clamp |=> wb_valid_o && (dest_idx_o == $past(instr_i[fpr_pkg::DEST_HI:fpr_pkg::DEST_LO]));
    endproperty
    a_clamp_issue: assert property (p_clamp_issue) else $error("clamp op not written back");

    property p_trunc_wh;
        s_exec_trunc_wh |=> result_o == {$past(first_src_i[31:16]), $past(second_src_i[31:16])};
    endproperty
    a_trunc_wh: assert property (p_trunc_wh) else $error("word truncation wrong");

    property p_trunc_hb;
        s_exec_trunc_hb |=> result_o == {$past(first_src_i[31:24]), $past(first_src_i[15:8]),
                                         $past(second_src_i[31:24]), $past(second_src_i[15:8])};
    endproperty
    a_trunc_hb: assert property (p_trunc_hb) else $error("byte truncation wrong");

    property p_clamp_high;
        s_exec_clamp ##0 (!first_src_i[31] && first_src_i[30:16] > fpr_pkg::CLAMP_LIMIT)
            |=> result_o[31:24] == fpr_pkg::BYTE_MAX && ctrl_we_o;
    endproperty
    a_clamp_high: assert property (p_clamp_high) else $error("high clamp missing");

    property p_clamp_low;
        s_exec_clamp ##0 second_src_i[15] |=> result_o[7:0] == fpr_pkg::BYTE_MIN && ctrl_we_o;
    endproperty
    a_clamp_low: assert property (p_clamp_low) else $error("low clamp missing");

    property p_clamp_pass;
        s_exec_clamp ##0 (first_src_i[15:0] == 16'h3f80)
            |=> result_o[23:16] == 8'h7f;
    endproperty
    a_clamp_pass: assert property (p_clamp_pass) else $error("magnitude byte wrong");

    property p_flag_merge;
        ctrl_we_o |-> ctrl_wdata_o == ($past(ctrl_i) | fpr_pkg::FLAG_MASK) && wb_valid_o;
    endproperty
    a_flag_merge: assert property (p_flag_merge) else $error("control write disturbs other bits");

    property p_round_sat;
        s_exec_round ##0 (second_src_i == 32'h7fff8000)
            |=> result_o[15:0] == 16'h7fff && ctrl_we_o;
    endproperty
    a_round_sat: assert property (p_round_sat) else $error("rounding saturation wrong");

    property p_round_plain;
        s_exec_round ##0 (first_src_i == 32'h12348000) ##0 (second_src_i == 32'hffff7fff)
            |=> result_o == 32'h1235ffff && !ctrl_we_o;
    endproperty
    a_round_plain: assert property (p_round_plain) else $error("rounding result wrong");

    property p_trunc_no_flag;
        (s_exec_trunc_wh or s_exec_trunc_hb) |=> !ctrl_we_o ##1 1'b1;
    endproperty
    a_trunc_no_flag: assert property (p_trunc_no_flag) else $error("truncation wrote control");

    property p_fault_excl;
        (ri_exc_o || disabled_exc_o) |-> !wb_valid_o && !ctrl_we_o && !(ri_exc_o && disabled_exc_o);
    endproperty
    a_fault_excl: assert property (p_fault_excl) else $error("fault with write-back");

    // Availability faults replace the write-back and never touch the control register.
    property p_absent_fault;
        s_take_absent |=> ri_exc_o && !wb_valid_o && !ctrl_we_o;
    endproperty
    a_absent_fault: assert property (p_absent_fault) else $error("absent extension not refused");

    property p_disabled_fault;
        s_take_disabled |=> disabled_exc_o && !wb_valid_o && !ctrl_we_o;
    endproperty
    a_disabled_fault: assert property (p_disabled_fault) else $error("disabled extension not refused");

    property p_idle_quiet;
        !(issue_i && hit_any)
            |=> !wb_valid_o && !ctrl_we_o && !ri_exc_o && !disabled_exc_o;
    endproperty
    a_idle_quiet: assert property (p_idle_quiet) else $error("output without a matching issue");

    property p_trunc_dest;
        (s_exec_trunc_wh or s_exec_trunc_hb) |=> wb_valid_o && (dest_idx_o == $past(instr_i[fpr_pkg::DEST_HI:fpr_pkg::DEST_LO]));
    endproperty
    a_trunc_dest: assert property (p_trunc_dest) else $error("truncation not written back");

    property p_round_issue;
        s_exec_round |=> wb_valid_o && (dest_idx_o == $past(instr_i[fpr_pkg::DEST_HI:fpr_pkg::DEST_LO]));
    endproperty
    a_round_issue: assert property (p_round_issue) else $error("rounding op not written back");

    // A negative halfword anywhere always clamps, so the flag write must follow.
    property p_clamp_flag;
        s_exec_clamp ##0 (first_src_i[31] || first_src_i[15] || second_src_i[31] || second_src_i[15])
            |=> ctrl_we_o;
    endproperty
    a_clamp_flag: assert property (p_clamp_flag) else $error("clamp flag write missing");

    // The fixed operand words below are patterns that the pipeline test drives; they pin
    // down boundaries that a generic comparison would only restate from the logic.
    property p_clamp_no_flag;
        s_exec_clamp ##0 (first_src_i == 32'h7f800000) ##0 (second_src_i == 32'h00ff0080)
            |=> result_o == 32'hff000101 && !ctrl_we_o;
    endproperty
    a_clamp_no_flag: assert property (p_clamp_no_flag) else $error("unclamped elements raised flag");

    property p_clamp_mid;
        s_exec_clamp ##0 (second_src_i[31:16] == 16'h7f80)
            |=> result_o[15:8] == fpr_pkg::BYTE_MAX;
    endproperty
    a_clamp_mid: assert property (p_clamp_mid) else $error("third clamp lane misplaced");

    property p_round_hi_sat;
        s_exec_round ##0 (first_src_i == 32'h7fff8000)
            |=> result_o[31:16] == 16'h7fff && ctrl_we_o;
    endproperty
    a_round_hi_sat: assert property (p_round_hi_sat) else $error("upper rounding saturation wrong");

    property p_round_order;
        s_exec_round ##0 (first_src_i == 32'h12348000) ##0 (second_src_i == 32'h7fff8000)
            |=> result_o == 32'h12357fff;
    endproperty
    a_round_order: assert property (p_round_order) else $error("rounded halves misplaced");

    property p_round_neg;
        s_exec_round ##0 (first_src_i == 32'hffff7fff) |=> result_o[31:16] == 16'hffff;
    endproperty
    a_round_neg: assert property (p_round_neg) else $error("rounding without carry wrong");

endmodule
`default_nettype wire
